/* File: pkg/fsp_pkg.sv */
// Function
// - One-bit overload protection select, reset disabled; disabled raises no overload fault.
// - Trip time scaled by gain 0.20 to 10.00, default 1.00.
// - At unity gain 175% rated current trips after 2 minutes.
// - At unity gain 115% rated current trips after 80 minutes.
// - Trip time held between 10 seconds and 80 minutes.
// - Trip time interpolated linearly in current between curve points.
// - Pre-warning output when accumulation exceeds curve times coefficient 50..120%, default 80%.
// - Ground-short test drives motor outputs after power-up when enabled, default enabled.
// - Brake unit runs above programmable bus threshold 200.0 to 2000.0 V.
// - Auto-reset up to 0..20 attempts, default 0, then fault stays latched.
// - One-bit select, default 0, drives fault output during auto-reset wait.
// - Auto-reset waits programmable interval 0.1 s to 100.0 s, default 1.0 s.
// - Input phase-loss and contactor protection enabled by two separate digits.
// - Output phase-loss protection only when selected, default on.
// - Three most recent fault codes readable, 0..99, 0 meaning none.
// - Frequency, current and bus voltage captured at the latest fault.
// - Ten digital inputs captured at latest fault, bit 0 is input one.
// - Five output terminals captured at latest fault in bits 0 to 4.
// - Power-on time captured at the latest fault.
// - Overload action: 0 coast, 1 stop by stop mode, 2 continue.
package fsp_pkg;
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned TICK_MS = 100;
  localparam int unsigned TICK_CYC = CLK_HZ / 1000 * TICK_MS;
  localparam int unsigned GND_TEST_MS = 10;
  localparam int unsigned GND_TEST_CYC = CLK_HZ / 1000 * GND_TEST_MS;
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_GAIN = 8'h04;
  localparam logic [7:0] A_WARN = 8'h08;
  localparam logic [7:0] A_BRAKE = 8'h0C;
  localparam logic [7:0] A_ARCNT = 8'h10;
  localparam logic [7:0] A_ARINT = 8'h14;
  localparam logic [7:0] A_CMD = 8'h18;
  localparam logic [7:0] A_STAT = 8'h1C;
  localparam logic [7:0] A_FT_OLD = 8'h20;
  localparam logic [7:0] A_FT_MID = 8'h24;
  localparam logic [7:0] A_FT_NEW = 8'h28;
  localparam logic [7:0] A_SN_FREQ = 8'h2C;
  localparam logic [7:0] A_SN_CUR = 8'h30;
  localparam logic [7:0] A_SN_BUS = 8'h34;
  localparam logic [7:0] A_SN_DI = 8'h38;
  localparam logic [7:0] A_SN_DO = 8'h3C;
  localparam logic [7:0] A_SN_STATE = 8'h40;
  localparam logic [7:0] A_SN_PON = 8'h44;
  localparam int CB_OL_EN = 0;
  localparam int CB_GND_EN = 1;
  localparam int CB_FDO_AR = 2;
  localparam int CB_INPH = 3;
  localparam int CB_CONT = 4;
  localparam int CB_OUTPH = 5;
  localparam int CB_ACT_LO = 8;
  localparam logic [9:0] CTRL_RST = 10'h02A;
  localparam logic [15:0] GAIN_RST = 16'h0064;
  localparam logic [15:0] GAIN_MIN = 16'h0014;
  localparam logic [15:0] GAIN_MAX = 16'h03E8;
  localparam logic [7:0] WARN_RST = 8'h50;
  localparam logic [7:0] WARN_MIN = 8'h32;
  localparam logic [7:0] WARN_MAX = 8'h78;
  localparam logic [15:0] BRAKE_MIN = 16'h07D0;
  localparam logic [15:0] BRAKE_MAX = 16'h4E20;
  localparam logic [15:0] BRAKE_RST = 16'h1F40;
  localparam logic [4:0] ARCNT_MAX = 5'h14;
  localparam logic [9:0] ARINT_RST = 10'h00A;
  localparam logic [9:0] ARINT_MIN = 10'h001;
  localparam logic [9:0] ARINT_MAX = 10'h3E8;
  localparam logic [15:0] OL_START_PCT = 16'h0073;
  localparam logic [15:0] OL_STEP_PCT = 16'h000A;
  localparam logic [15:0] T_MIN_TICKS = 16'h0064;
  localparam logic [15:0] T_MAX_TICKS = 16'hBB80;
  localparam logic [6:0] CODE_OVERLOAD = 7'h0B;
  localparam logic [6:0] CODE_IN_PHASE = 7'h0C;
  localparam logic [6:0] CODE_OUT_PHASE = 7'h0D;
  localparam logic [6:0] CODE_CONTACTOR = 7'h11;
  localparam logic [1:0] ACT_COAST = 2'h0;
  localparam logic [1:0] ACT_RAMP = 2'h1;
  typedef struct packed {
    logic [15:0] freq;
    logic [15:0] current;
    logic [15:0] bus;
    logic [9:0] di;
    logic [4:0] dout;
    logic [15:0] pon;
  } fsp_snap_t;
  typedef enum logic [2:0] {
    ST_RUN = 3'b001,
    ST_WAIT = 3'b010,
    ST_LATCH = 3'b100
  } fsp_state_t;
endpackage : fsp_pkg

/* File: rtl/fsp_supervisor.sv */
`timescale 1ns/10ps
module fsp_supervisor import fsp_pkg::*; #(
  parameter int unsigned P_TICK_CYC = TICK_CYC,
  parameter int unsigned P_GND_CYC = GND_TEST_CYC,
  parameter logic [15:0] P_BRAKE_RST = BRAKE_RST
) (
  input wire logic i_core_clk,
  input wire logic i_reset,
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic i_running,
  input wire fsp_snap_t i_snap,
  input wire logic i_in_phase_loss,
  input wire logic i_out_phase_loss,
  input wire logic i_contactor_fault,
  input wire logic i_ext_fault,
  input wire logic [6:0] i_ext_code,
  output logic [31:0] o_rdata,
  output logic o_overload_warn,
  output logic o_fault_do,
  output logic o_coast_stop,
  output logic o_ramp_stop,
  output logic o_auto_reset,
  output logic o_brake_on,
  output logic o_gnd_test
);
  generate
    if (P_TICK_CYC < 2 || P_GND_CYC < 1) begin : g_bad
      $error("fsp_supervisor: tick or test length too small");
    end
    if (P_BRAKE_RST < BRAKE_MIN || P_BRAKE_RST > BRAKE_MAX) begin : g_bad_brake
      // Default must lie in the range that software may write
      $error("fsp_supervisor: brake threshold default out of range");
    end
  endgenerate

  // Curve knots at 115,125..175 %, in 0.1 s ticks
  function automatic logic [15:0] knot(input logic [2:0] k);
    case (k)
      3'd0: knot = 16'hBB80;
      3'd1: knot = 16'h5DC0;
      3'd2: knot = 16'h2EE0;
      3'd3: knot = 16'h0E10;
      3'd4: knot = 16'h0960;
      3'd5: knot = 16'h0708;
      default: knot = 16'h04B0;
    endcase
  endfunction : knot

  logic [9:0] ctrl_r;
  logic [15:0] gain_r;
  logic [7:0] warn_r;
  logic [15:0] brake_r;
  logic [4:0] arcnt_r;
  logic [9:0] arint_r;
  logic [4:0] budget_r;
  fsp_state_t state_r;
  logic [31:0] tick_cnt_r;
  logic tick_r;
  logic [15:0] acc_r;
  logic [9:0] wait_r;
  logic [6:0] ft_r [3];
  fsp_snap_t snap_r;
  logic [31:0] gnd_cnt_r;
  logic gnd_done_r;
  logic [31:0] rdata_r;
  logic warn_o_r;
  logic fdo_r;
  logic coast_r;
  logic ramp_r;
  logic ar_r;
  logic brake_o_r;
  logic gnd_o_r;

  wire wr_ctrl = i_wr && i_addr == A_CTRL;
  wire wr_gain = i_wr && i_addr == A_GAIN;
  wire wr_warn = i_wr && i_addr == A_WARN;
  wire wr_brake = i_wr && i_addr == A_BRAKE;
  wire wr_arcnt = i_wr && i_addr == A_ARCNT;
  wire wr_arint = i_wr && i_addr == A_ARINT;
  wire man_reset = i_wr && i_addr == A_CMD && i_wdata[0];
  wire [15:0] wd16 = i_wdata[15:0];

  // Overload curve lookup and scaling
  wire ol_en = ctrl_r[CB_OL_EN];
  wire [15:0] cur = i_snap.current;
  wire over = cur >= OL_START_PCT;
  wire [15:0] rel = over ? cur - OL_START_PCT : 16'h0000;
  wire [15:0] seg16 = rel / OL_STEP_PCT;
  wire top_seg = seg16 >= 16'h0006;
  wire [2:0] seg = top_seg ? 3'd6 : seg16[2:0];
  wire [15:0] frac = top_seg ? 16'h0000 : rel % OL_STEP_PCT;
  wire [2:0] seg_nx = top_seg ? 3'd6 : seg + 3'd1;
  wire [31:0] drop = 32'(knot(seg) - knot(seg_nx)) * 32'(frac) / 32'(OL_STEP_PCT);
  wire [31:0] t_base = 32'(knot(seg)) - drop;
  wire [31:0] t_scaled = t_base * 32'(gain_r) / 32'd100;
  wire [15:0] trip_t = t_scaled > 32'(T_MAX_TICKS) ? T_MAX_TICKS
                     : t_scaled < 32'(T_MIN_TICKS) ? T_MIN_TICKS : t_scaled[15:0];
  wire heating = ol_en && i_running && over;
  wire ol_trip = heating && acc_r >= trip_t;
  wire warn_now = heating && 32'(acc_r) * 32'd100 > 32'(trip_t) * 32'(warn_r);

  // Fault arbitration, overload first
  wire inph = ctrl_r[CB_INPH] && i_in_phase_loss;
  wire cont = ctrl_r[CB_CONT] && i_contactor_fault;
  wire outph = ctrl_r[CB_OUTPH] && i_out_phase_loss;
  wire any_fault = ol_trip || inph || outph || cont || i_ext_fault;
  wire [6:0] new_code = ol_trip ? CODE_OVERLOAD : inph ? CODE_IN_PHASE
                      : outph ? CODE_OUT_PHASE : cont ? CODE_CONTACTOR
                      : i_ext_code;
  wire fault_evt = state_r == ST_RUN && any_fault;
  wire [1:0] ol_act = ctrl_r[CB_ACT_LO +: 2];
  wire wait_done = state_r == ST_WAIT && tick_r && wait_r + 10'd1 >= arint_r;

  function automatic logic [31:0] rd_word(input logic [7:0] a);
    case (a)
      A_CTRL: rd_word = {22'h0, ctrl_r};
      A_GAIN: rd_word = {16'h0, gain_r};
      A_WARN: rd_word = {24'h0, warn_r};
      A_BRAKE: rd_word = {16'h0, brake_r};
      A_ARCNT: rd_word = {27'h0, arcnt_r};
      A_ARINT: rd_word = {22'h0, arint_r};
      A_STAT: rd_word = {11'h0, budget_r, 8'h0, 1'b0, brake_o_r, warn_o_r,
                         gnd_done_r, 1'b0, state_r};
      A_FT_OLD: rd_word = {25'h0, ft_r[0]};
      A_FT_MID: rd_word = {25'h0, ft_r[1]};
      A_FT_NEW: rd_word = {25'h0, ft_r[2]};
      A_SN_FREQ: rd_word = {16'h0, snap_r.freq};
      A_SN_CUR: rd_word = {16'h0, snap_r.current};
      A_SN_BUS: rd_word = {16'h0, snap_r.bus};
      A_SN_DI: rd_word = {22'h0, snap_r.di};
      A_SN_DO: rd_word = {27'h0, snap_r.dout};
      A_SN_PON: rd_word = {16'h0, snap_r.pon};
      default: rd_word = 32'h0;
    endcase
  endfunction : rd_word

  wire [31:0] rd_val = rd_word(i_addr);

  // Configuration; out-of-range writes are dropped, not clamped
  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      ctrl_r <= CTRL_RST;
      gain_r <= GAIN_RST;
      warn_r <= WARN_RST;
      brake_r <= P_BRAKE_RST;
      arcnt_r <= 5'h0;
      arint_r <= ARINT_RST;
    end else begin
      if (wr_ctrl) ctrl_r <= i_wdata[9:0];
      if (wr_gain && wd16 >= GAIN_MIN && wd16 <= GAIN_MAX) gain_r <= wd16;
      if (wr_warn && i_wdata[7:0] >= WARN_MIN && i_wdata[7:0] <= WARN_MAX) begin
        warn_r <= i_wdata[7:0];
      end
      if (wr_brake && wd16 >= BRAKE_MIN && wd16 <= BRAKE_MAX) brake_r <= wd16;
      if (wr_arcnt && i_wdata[4:0] <= ARCNT_MAX) arcnt_r <= i_wdata[4:0];
      if (wr_arint && i_wdata[9:0] >= ARINT_MIN && i_wdata[9:0] <= ARINT_MAX) begin
        arint_r <= i_wdata[9:0];
      end
    end
  end

  // 0.1 s time base
  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      tick_cnt_r <= 32'h0;
      tick_r <= 1'b0;
    end else begin
      tick_r <= tick_cnt_r == P_TICK_CYC - 1;
      tick_cnt_r <= tick_cnt_r == P_TICK_CYC - 1 ? 32'h0 : tick_cnt_r + 32'h1;
    end
  end

  // Overload accumulation, cools at the same rate when below the curve
  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) acc_r <= 16'h0;
    else if (fault_evt || !ol_en) acc_r <= 16'h0;
    else if (tick_r && heating && acc_r != 16'hFFFF) acc_r <= acc_r + 16'h1;
    else if (tick_r && !heating && acc_r != 16'h0) acc_r <= acc_r - 16'h1;
  end

  // Fault sequencer and auto-reset
  // Budget never wraps if software zeroes it during a wait
  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      state_r <= ST_RUN;
      budget_r <= 5'h0;
      wait_r <= 10'h0;
    end else begin
      if (fault_evt) begin
        wait_r <= 10'h0;
        state_r <= budget_r != 5'h0 ? ST_WAIT : ST_LATCH;
      end else if (man_reset && state_r != ST_RUN) begin
        state_r <= ST_RUN;
      end else if (wait_done) begin
        state_r <= ST_RUN;
      end else if (state_r == ST_WAIT && tick_r) begin
        wait_r <= wait_r + 10'd1;
      end
      if (wr_arcnt && i_wdata[4:0] <= ARCNT_MAX) budget_r <= i_wdata[4:0];
      else if (man_reset && state_r != ST_RUN) budget_r <= arcnt_r;
      else if (wait_done && budget_r != 5'h0) budget_r <= budget_r - 5'h1;
    end
  end

  // History and snapshot
  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      ft_r[0] <= 7'h0;
      ft_r[1] <= 7'h0;
      ft_r[2] <= 7'h0;
      snap_r <= '0;
    end else if (fault_evt) begin
      ft_r[0] <= ft_r[1];
      ft_r[1] <= ft_r[2];
      ft_r[2] <= new_code;
      snap_r <= i_snap;
    end
  end

  // Power-up ground-short test; clearing the enable aborts it
  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      gnd_cnt_r <= 32'h0;
      gnd_done_r <= 1'b0;
    end else if (!gnd_done_r) begin
      gnd_cnt_r <= gnd_cnt_r + 32'h1;
      gnd_done_r <= !ctrl_r[CB_GND_EN] || gnd_cnt_r == P_GND_CYC - 1;
    end
  end

  // Registered outputs
  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      rdata_r <= 32'h0;
      warn_o_r <= 1'b0;
      fdo_r <= 1'b0;
      coast_r <= 1'b0;
      ramp_r <= 1'b0;
      ar_r <= 1'b0;
      brake_o_r <= 1'b0;
      gnd_o_r <= 1'b0;
    end else begin
      rdata_r <= i_rd ? rd_val : 32'h0;
      warn_o_r <= warn_now;
      fdo_r <= state_r == ST_LATCH || (state_r == ST_WAIT && ctrl_r[CB_FDO_AR]);
      if (fault_evt) begin
        coast_r <= !(ol_trip && ol_act != ACT_COAST);
        ramp_r <= ol_trip && ol_act == ACT_RAMP;
      end else if (state_r == ST_RUN) begin
        coast_r <= 1'b0;
        ramp_r <= 1'b0;
      end
      ar_r <= wait_done;
      brake_o_r <= i_snap.bus >= brake_r;
      gnd_o_r <= !gnd_done_r && ctrl_r[CB_GND_EN] && gnd_cnt_r != P_GND_CYC - 1;
    end
  end

  assign o_rdata = rdata_r;
  assign o_overload_warn = warn_o_r;
  assign o_fault_do = fdo_r;
  assign o_coast_stop = coast_r;
  assign o_ramp_stop = ramp_r;
  assign o_auto_reset = ar_r;
  assign o_brake_on = brake_o_r;
  assign o_gnd_test = gnd_o_r;

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_reset);

  // Disabled protection must also forget any heat it had counted
  AST_OL_DISABLED: assert property (!ol_en |=> acc_r == 16'h0 && !o_overload_warn)
    else $error("overload state kept while protection disabled");
  AST_TRIP_BOUNDS: assert property (trip_t >= T_MIN_TICKS && trip_t <= T_MAX_TICKS)
    else $error("trip time outside bounds");
  AST_UNITY_175: assert property ((gain_r == GAIN_RST && cur >= 16'd175)
      |-> trip_t == 16'h04B0)
    else $error("175 percent trip time not 2 minutes");
  AST_UNITY_115: assert property ((gain_r == GAIN_RST && cur == OL_START_PCT)
      |-> trip_t == T_MAX_TICKS)
    else $error("115 percent trip time not 80 minutes");
  AST_INTERP_150: assert property ((gain_r == GAIN_RST && cur == 16'd150)
      |-> trip_t == 16'h0BB8)
    else $error("150 percent not 5 minutes");
  AST_WARN_OUT: assert property (warn_now |=> o_overload_warn)
    else $error("warning output missed");
  AST_HISTORY: assert property (fault_evt |=> ft_r[2] == $past(new_code)
      && ft_r[1] == $past(ft_r[2]) && ft_r[0] == $past(ft_r[1]))
    else $error("fault history not shifted");
  AST_LATCH_EMPTY: assert property ((fault_evt && budget_r == 5'h0)
      |=> state_r == ST_LATCH ##1 o_fault_do)
    else $error("exhausted budget did not latch");
  AST_BUDGET_DOWN: assert property ((wait_done && !wr_arcnt && budget_r != 5'h0)
      |=> budget_r == $past(budget_r) - 5'h1 ##0 o_auto_reset)
    else $error("budget not decremented on auto reset");
  AST_FDO_WAIT: assert property ((state_r == ST_WAIT && !ctrl_r[CB_FDO_AR])
      |=> !o_fault_do)
    else $error("fault output driven during auto reset wait");
  AST_OUTPH_OFF: assert property ((state_r == ST_RUN && !ctrl_r[CB_OUTPH]
      && i_out_phase_loss && !i_ext_fault && !ol_trip && !inph && !cont) |=> state_r == ST_RUN)
    else $error("disabled output phase loss raised a fault");
  AST_SNAP: assert property (fault_evt |=> snap_r == $past(i_snap))
    else $error("snapshot not captured");
  AST_BRAKE: assert property (i_snap.bus >= brake_r |=> o_brake_on)
    else $error("brake not started above threshold");
  AST_BRAKE_OFF: assert property (i_snap.bus < brake_r |=> !o_brake_on)
    else $error("brake running below threshold");
  AST_GND_SKIP: assert property (!ctrl_r[CB_GND_EN] |=> !o_gnd_test)
    else $error("ground test drive while check disabled");
  AST_RDATA_IDLE: assert property (!i_rd |=> o_rdata == 32'h0)
    else $error("read data shown without a read");
  AST_AR_PULSE: assert property (o_auto_reset |=> !o_auto_reset)
    else $error("auto reset pulse longer than one cycle");
  AST_WAIT_ENTER: assert property ((fault_evt && budget_r != 5'h0)
      |=> state_r == ST_WAIT)
    else $error("fault with budget left did not wait");
  AST_MAN_RESET: assert property ((man_reset && state_r != ST_RUN)
      |=> state_r == ST_RUN && budget_r == $past(arcnt_r))
    else $error("manual reset did not restore budget");
  AST_STOP_CLEAR: assert property ((state_r == ST_RUN && !fault_evt)
      |=> !o_coast_stop && !o_ramp_stop)
    else $error("stop request held while running");
  AST_GAIN_KEEP: assert property ((wr_gain && (wd16 < GAIN_MIN || wd16 > GAIN_MAX))
      |=> gain_r == $past(gain_r))
    else $error("out of range gain accepted");
  AST_CFG_RANGE: assert property (gain_r >= GAIN_MIN && gain_r <= GAIN_MAX
      && warn_r >= WARN_MIN && warn_r <= WARN_MAX)
    else $error("gain or warning coefficient out of range");
  AST_BUDGET_RANGE: assert property (arcnt_r <= ARCNT_MAX && budget_r <= ARCNT_MAX)
    else $error("auto reset budget out of range");
  AST_HIST_HOLD: assert property (!fault_evt |=> ft_r[2] == $past(ft_r[2]))
    else $error("latest fault code changed without a fault");

  // Main scenarios
  COV_OL_TRIP: cover property (ol_trip && state_r == ST_RUN);
  COV_AUTO_RESET: cover property (o_auto_reset);
  COV_LATCH_MANUAL: cover property (state_r == ST_LATCH && man_reset);
  COV_WARN: cover property (o_overload_warn ##1 ol_trip);
  COV_OL_CONTINUE: cover property (fault_evt && ol_trip && ol_act[1]);
endmodule : fsp_supervisor

/* File: verif/tb_top.sv */
`timescale 1ns/10ps
module tb_top;
  import fsp_pkg::*;
  localparam int unsigned TK = 20;
  localparam logic [7:0] CFG_A [7] = '{A_CTRL, A_GAIN, A_WARN, A_BRAKE, A_ARCNT, A_ARINT, 8'h48};
  localparam logic [31:0] CFG_E [7] = '{32'h2A, 32'h64, 32'h50, {16'h0, BRAKE_RST}, 32'h0,
    32'hA, 32'h0};
  localparam logic [7:0] SN_A [7] = '{A_SN_FREQ, A_SN_CUR, A_SN_BUS, A_SN_DI, A_SN_DO,
    A_SN_STATE, A_SN_PON};
  localparam logic [31:0] SN_E [7] = '{32'h1388, 32'hAF, 32'hFA0, 32'h2A5, 32'h15, 32'h0,
    32'hBCD};
  logic i_core_clk = 1'h0;
  logic i_reset = 1'h1;
  logic [7:0] i_addr = 8'h00;
  logic [31:0] i_wdata = 32'h0;
  logic i_wr = 1'h0;
  logic i_rd = 1'h0;
  logic i_running = 1'h0;
  fsp_snap_t i_snap = '0;
  logic i_in_phase_loss = 1'h0;
  logic i_out_phase_loss = 1'h0;
  logic i_contactor_fault = 1'h0;
  logic i_ext_fault = 1'h0;
  logic [6:0] i_ext_code = 7'h00;
  logic [31:0] o_rdata;
  logic o_overload_warn, o_fault_do, o_coast_stop, o_ramp_stop, o_auto_reset, o_brake_on;
  logic o_gnd_test;
  int n_fail = 0;
  int num_checks = 0;
  int t;
  always #12.5 i_core_clk = ~i_core_clk;
  fsp_supervisor #(.P_TICK_CYC(TK), .P_GND_CYC(10)) fsp_supervisor_i (
    .i_core_clk(i_core_clk), .i_reset(i_reset), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .i_running(i_running), .i_snap(i_snap),
    .i_in_phase_loss(i_in_phase_loss), .i_out_phase_loss(i_out_phase_loss),
    .i_contactor_fault(i_contactor_fault), .i_ext_fault(i_ext_fault), .i_ext_code(i_ext_code),
    .o_rdata(o_rdata), .o_overload_warn(o_overload_warn), .o_fault_do(o_fault_do),
    .o_coast_stop(o_coast_stop), .o_ramp_stop(o_ramp_stop), .o_auto_reset(o_auto_reset),
    .o_brake_on(o_brake_on), .o_gnd_test(o_gnd_test));
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : conclude
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  function automatic logic pick(input int w);
    case (w)
      0: pick = o_gnd_test;
      1: pick = o_overload_warn;
      2: pick = o_coast_stop;
      3: pick = o_ramp_stop;
      4: pick = o_auto_reset;
      6: pick = o_brake_on;
      default: pick = o_fault_do;
    endcase
  endfunction : pick
  // Sample just after the edge so registered outputs have settled, then realign
  task automatic peek(input string nm, input int w, input logic exp);
    #1;
    chk(nm, {31'h0, exp}, {31'h0, pick(w)});
    @(posedge i_core_clk);
  endtask : peek
  task automatic wait_for(input int w, input logic lvl, input int lim, output int n);
    n = 0;
    #1;
    while (pick(w) !== lvl) begin
      @(posedge i_core_clk);
      #1;
      n++;
      if (n > lim) begin
        n_fail++;
        $display("[FAIL] wait %0d expected %h seen none", w, lvl);
        conclude();
      end
    end
    @(posedge i_core_clk);
  endtask : wait_for
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'h1;
    @(posedge i_core_clk);
    i_wr <= 1'h0;
    @(posedge i_core_clk);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string nm);
    i_addr <= a;
    i_rd <= 1'h1;
    @(posedge i_core_clk);
    i_rd <= 1'h0;
    #1;
    chk(nm, exp, o_rdata);
    @(posedge i_core_clk);
  endtask : rd
  task automatic cfg_all;
    for (int i = 0; i < 7; i++) begin
      rd(CFG_A[i], CFG_E[i], "config");
    end
  endtask : cfg_all
  task automatic ext(input logic [6:0] c);
    i_ext_code <= c;
    i_ext_fault <= 1'h1;
    @(posedge i_core_clk);
    i_ext_fault <= 1'h0;
    repeat (3) @(posedge i_core_clk);
  endtask : ext
  // Raise one detector, then drop it before the manual clear so it cannot re-trip
  task automatic det(input int k, input logic [6:0] exp);
    i_in_phase_loss <= (k == 0);
    i_out_phase_loss <= (k == 1);
    i_contactor_fault <= (k == 2);
    repeat (3) @(posedge i_core_clk);
    i_in_phase_loss <= 1'h0;
    i_out_phase_loss <= 1'h0;
    i_contactor_fault <= 1'h0;
    rd(A_FT_NEW, {25'h0, exp}, "latest_code");
    wr(A_CMD, 32'h1);
  endtask : det
  // Tick phase is unknown, so allow two ticks either way
  task automatic ol_run(input logic [15:0] cur, input int warn_c, input int trip_c, input int w);
    int t1;
    int t2;
    i_snap.current <= cur;
    i_running <= 1'h1;
    wait_for(1, 1'h1, trip_c, t1);
    chk("warn_time", 32'h1, {31'h0, (t1 >= warn_c - 40 && t1 <= warn_c + 40)});
    wait_for(w, 1'h1, trip_c, t2);
    chk("trip_time", 32'h1, {31'h0, (t1 + t2 >= trip_c - 40 && t1 + t2 <= trip_c + 40)});
    i_running <= 1'h0;
  endtask : ol_run
  initial begin
    repeat (12) @(posedge i_core_clk);
    i_reset <= 1'h0;
    @(posedge i_core_clk);
    peek("gnd_test", 0, 1'h1);
    wait_for(0, 1'h0, 40, t);
    cfg_all();
    rd(A_STAT, 32'h11, "status");
    rd(A_FT_NEW, 32'h0, "latest_code");
    wr(A_GAIN, 32'h13);
    wr(A_GAIN, 32'h3E9);
    wr(A_WARN, 32'h79);
    wr(A_BRAKE, 32'h7CF);
    wr(A_ARCNT, 32'h15);
    wr(A_ARINT, 32'h0);
    cfg_all();
    wr(A_BRAKE, 32'hFA0);
    i_snap <= '{freq: 16'h1388, current: 16'hAF, bus: 16'hF9F, di: 10'h2A5, dout: 5'h15,
      pon: 16'hBCD};
    repeat (3) @(posedge i_core_clk);
    peek("brake", 6, 1'h0);
    i_snap.bus <= 16'hFA0;
    repeat (3) @(posedge i_core_clk);
    peek("brake", 6, 1'h1);
    ext(7'h21);
    rd(A_STAT, 32'h54, "status");
    peek("fault_do", 5, 1'h1);
    peek("coast", 2, 1'h1);
    for (int i = 0; i < 7; i++) begin
      rd(SN_A[i], SN_E[i], "snapshot");
    end
    i_snap.freq <= 16'h0;
    i_snap.current <= 16'h96;
    ext(7'h22);
    rd(A_FT_NEW, 32'h21, "latest_code");
    rd(A_SN_FREQ, 32'h1388, "snapshot");
    wr(A_CMD, 32'h1);
    peek("fault_do", 5, 1'h0);
    ext(7'h22);
    wr(A_CMD, 32'h1);
    ext(7'h23);
    rd(A_FT_OLD, 32'h21, "oldest_code");
    rd(A_FT_MID, 32'h22, "middle_code");
    rd(A_FT_NEW, 32'h23, "latest_code");
    wr(A_CMD, 32'h1);
    i_snap.current <= 16'h73;
    wr(A_CTRL, 32'h0A);
    det(1, 7'h23);
    det(2, 7'h23);
    wr(A_CTRL, 32'h3A);
    det(0, 7'h0C);
    det(1, 7'h0D);
    det(2, 7'h11);
    wr(A_ARCNT, 32'h1);
    wr(A_ARINT, 32'h3);
    ext(7'h24);
    rd(A_STAT, 32'h10052, "status");
    peek("fault_do", 5, 1'h0);
    wait_for(4, 1'h1, 80, t);
    chk("interval", 32'h1, {31'h0, (t >= 30 && t <= 70)});
    rd(A_STAT, 32'h51, "status");
    ext(7'h25);
    rd(A_STAT, 32'h54, "status");
    wr(A_CMD, 32'h1);
    rd(A_STAT, 32'h10051, "status");
    wr(A_CTRL, 32'h3E);
    ext(7'h26);
    peek("fault_do", 5, 1'h1);
    wait_for(4, 1'h1, 80, t);
    wr(A_ARCNT, 32'h0);
    wr(A_CTRL, 32'h0A);
    wr(A_GAIN, 32'h14);
    i_snap.current <= 16'hAF;
    i_running <= 1'h1;
    repeat (300 * TK) @(posedge i_core_clk);
    peek("coast", 2, 1'h0);
    rd(A_FT_NEW, 32'h26, "latest_code");
    i_running <= 1'h0;
    wr(A_CTRL, 32'h0B);
    ol_run(16'hAF, 193 * TK, 240 * TK, 2);
    rd(A_FT_NEW, 32'h0B, "latest_code");
    repeat (450 * TK) @(posedge i_core_clk);
    wr(A_CMD, 32'h1);
    wr(A_CTRL, 32'h10B);
    wr(A_WARN, 32'h32);
    ol_run(16'h96, 301 * TK, 600 * TK, 3);
    peek("coast", 2, 1'h0);
    i_reset <= 1'h1;
    repeat (2) @(posedge i_core_clk);
    i_reset <= 1'h0;
    @(posedge i_core_clk);
    peek("ramp", 3, 1'h0);
    wr(A_CTRL, 32'h28);
    peek("gnd_test", 0, 1'h0);
    rd(A_STAT, 32'h11, "status");
    rd(A_FT_NEW, 32'h0, "latest_code");
    rd(A_BRAKE, {16'h0, BRAKE_RST}, "brake_default");
    conclude();
  end
endmodule : tb_top
